// ==== rtl/ccs_defs.svh ====
// timing counts, codes and reset values for the conversion clock select block
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
`define CCS_CLK_MHZ      50
`define CCS_CONV60_US    66600
`define CCS_CONV50_US    80000
`define CCS_CONV_TICKS   10278
`define CCS_DET_WIN_US   400
`define CCS_DET_EDGES    3'h2
`define CCS_SCK_HALF     2'h3
`define CCS_OVER_WORD    32'h3000_0000
`define CCS_UNDER_WORD   32'h0FFF_FFFF
`define CCS_WORD_RST     32'h0000_0000
`define CCS_SIGN_BIT     29
`define CCS_MAG_MSB      28
`endif

// ==== rtl/ccs_pkg.sv ====
// types shared by the conversion clock select block
package ccs_pkg;
    typedef enum logic [1:0] {
        CCS_SLEEP = 2'b01,
        CCS_CONV  = 2'b10
    } ccs_state_t;
endpackage

// ==== rtl/ccs_top.sv ====
// conversion clock source select, conversion sequencer and output word coding
`timescale 1ns/1ps
`include "ccs_defs.svh"

module ccs_top #(
    parameter logic [13:0] CONV_TICKS  = 14'(`CCS_CONV_TICKS),                 // ticks per conversion
    parameter logic [14:0] DET_WIN_CYC = 15'(`CCS_DET_WIN_US * `CCS_CLK_MHZ)    // detect window
) (
    input  wire logic                 clk,                        // 50 MHz system clock
    input  wire logic                 rst,                        // async reset, active high
    input  wire logic                 rejection_select_clock_pin, // level select or ext clock
    input  wire logic                 start_conv,                 // pulse: begin a conversion
    input  wire logic                 result_valid,               // pulse: modulator result ready
    input  wire logic                 result_over,                // result above full scale
    input  wire logic                 result_under,               // result below full scale
    input  wire logic signed [28:0]   result_value,               // in-range two's-complement value
    input  wire logic                 sck_run,                    // internal serial clock wanted
    output logic                      ext_clk_mode,               // external conversion clock in use
    output logic                      notch_50hz,                 // 50Hz timing latched
    output logic                      eoc_bit,                    // high while converting
    output logic                      conv_done,                  // pulse: conversion finished
    output logic                      conv_tick,                  // pulse: one conversion clock
    output logic                      sck_int,                    // internal serial clock
    output logic [31:0]               out_word,                   // coded 32-bit output word
    output ccs_pkg::ccs_state_t       conv_state                  // sleep or convert
);
    import ccs_pkg::*;

    // internal oscillator tick periods, rounded up so 60Hz timing lands on 66.6ms;
    // rounding down would cut the 60Hz conversion to 66.4ms
    localparam logic [8:0] OSC60_LIM = 9'((`CCS_CONV60_US * `CCS_CLK_MHZ + `CCS_CONV_TICKS - 1)
        / `CCS_CONV_TICKS - 1);
    localparam logic [8:0] OSC50_LIM = 9'((`CCS_CONV50_US * `CCS_CLK_MHZ + `CCS_CONV_TICKS - 1)
        / `CCS_CONV_TICKS - 1);

    typedef struct packed {
        logic        s1;        // synchroniser first stage
        logic        s2;        // synchroniser second stage
        logic        s3;        // previous synced level for edges
        logic [14:0] win_cnt;   // detection window counter
        logic [2:0]  edge_cnt;  // edges seen in this window
        logic        ext;       // external clock detected
        logic [8:0]  osc_cnt;   // internal oscillator divider
        logic        tick;      // conversion clock tick
        ccs_state_t  state;     // sequencer state
        logic [13:0] conv_cnt;  // ticks into the conversion
        logic        notch50;   // latched rejection selection
        logic        eoc;       // end-of-conversion bit
        logic        done;      // conversion finished pulse
        logic [1:0]  sck_div;   // ticks since last sck toggle
        logic        sck;       // internal serial clock
        logic [31:0] word;      // coded result
    } ccs_state_s_t;

    ccs_state_s_t r;
    ccs_state_s_t n;

    logic pin_edge;
    logic pin_rise;
    logic win_end;

    // edges are taken only from the second stage onward
    assign pin_edge = r.s2 ^ r.s3;
    assign pin_rise = r.s2 & ~r.s3;
    assign win_end  = (r.win_cnt == DET_WIN_CYC - 15'h0001);

    always_comb begin
        n      = r;
        n.tick = 1'b0;
        n.done = 1'b0;
        // pin synchroniser
        n.s1 = rejection_select_clock_pin;
        n.s2 = r.s1;
        n.s3 = r.s2;

        // clock detection: 2560Hz gives at least two edges in a 400us window
        if (win_end) begin
            n.win_cnt  = 15'h0000;
            n.edge_cnt = 3'h0;
            n.ext      = (r.edge_cnt >= `CCS_DET_EDGES);
        end else begin
            n.win_cnt = r.win_cnt + 15'h0001;
            if (pin_edge && (r.edge_cnt != 3'h7)) begin
                n.edge_cnt = r.edge_cnt + 3'h1;
            end
        end

        // conversion clock source; a switch mid-conversion only skews that conversion
        if (r.ext) begin
            n.osc_cnt = 9'h000; // internal oscillator held off
            n.tick    = pin_rise; // one tick per external period
        end else if (r.osc_cnt >= (r.notch50 ? OSC50_LIM : OSC60_LIM)) begin
            n.osc_cnt = 9'h000;
            n.tick    = 1'b1;
        end else begin
            n.osc_cnt = r.osc_cnt + 9'h001;
        end

        // sequencer; selection is latched only at start, so sleep changes are harmless
        case (r.state)
            CCS_SLEEP: begin
                if (start_conv) begin
                    n.state    = CCS_CONV;
                    n.conv_cnt = 14'h0000;
                    n.eoc      = 1'b1;
                    if (!r.ext) begin
                        n.notch50 = r.s2;
                    end
                end
            end
            CCS_CONV: begin
                // a level change now is ignored until next start
                if (r.tick) begin
                    if (r.conv_cnt == CONV_TICKS - 14'h0001) begin
                        n.state = CCS_SLEEP;
                        n.eoc   = 1'b0;
                        n.done  = 1'b1;
                    end else begin
                        n.conv_cnt = r.conv_cnt + 14'h0001;
                    end
                end
            end
            default: begin
                n.state = CCS_SLEEP;
                n.eoc   = 1'b0;
            end
        endcase

        // serial clock from conversion ticks; a source change only stretches or shortens half periods
        if (!sck_run) begin
            n.sck_div = 2'h0;
            n.sck     = 1'b0;
        end else if (r.tick) begin
            if (r.sck_div == `CCS_SCK_HALF) begin
                n.sck_div = 2'h0;
                n.sck     = ~r.sck;
            end else begin
                n.sck_div = r.sck_div + 2'h1;
            end
        end

        // output word coding; bit 31 is zero since a result means conversion done
        if (result_valid) begin
            if (result_over) begin
                n.word = `CCS_OVER_WORD;
            end else if (result_under) begin
                n.word = `CCS_UNDER_WORD;
            end else begin
                n.word = {1'b0, 1'b0, ~result_value[`CCS_MAG_MSB], result_value};
            end
        end
    end

    // state register; every field resets to a constant
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r.s1       <= 1'b0;
            r.s2       <= 1'b0;
            r.s3       <= 1'b0;
            r.win_cnt  <= 15'h0000;
            r.edge_cnt <= 3'h0;
            r.ext      <= 1'b0;
            r.osc_cnt  <= 9'h000;
            r.tick     <= 1'b0;
            r.state    <= CCS_SLEEP;
            r.conv_cnt <= 14'h0000;
            r.notch50  <= 1'b0;
            r.eoc      <= 1'b0;
            r.done     <= 1'b0;
            r.sck_div  <= 2'h0;
            r.sck      <= 1'b0;
            r.word     <= `CCS_WORD_RST;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign ext_clk_mode = r.ext;
    assign notch_50hz   = r.notch50;
    assign eoc_bit      = r.eoc;
    assign conv_done    = r.done;
    assign conv_tick    = r.tick;
    assign sck_int      = r.sck;
    assign out_word     = r.word;
    assign conv_state   = r.state;

    // the host keeps the pin low and averages for the dual-notch variant

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_valid_over;
        result_valid && result_over;
    endsequence

    sequence s_valid_in;
        result_valid && !result_over && !result_under;
    endsequence

    sequence s_start_internal;
        (r.state == CCS_SLEEP) && start_conv && !r.ext;
    endsequence

    a_over_code: assert property (s_valid_over |=> out_word == 32'h3000_0000)
        else $error("overrange word wrong");

    a_under_code: assert property (result_valid && !result_over && result_under
        |=> out_word == 32'h0FFF_FFFF)
        else $error("underrange word wrong");

    a_polarity_bit: assert property (s_valid_in
        |=> out_word[29] == !$past(result_value[28]) && out_word[31:30] == 2'b00
            && out_word[28:0] == $past(result_value))
        else $error("in-range word wrong");

    a_notch_latch: assert property (s_start_internal ##0 (r.s2 == 1'b1)
        |=> notch_50hz ##1 (notch_50hz throughout (conv_state == CCS_CONV)[*2]))
        else $error("50Hz selection not latched");

    a_notch_stable: assert property ($changed(notch_50hz)
        |-> $past(start_conv) && $past(r.state) == CCS_SLEEP)
        else $error("selection changed outside conversion start");

    a_ext_detect: assert property (win_end && r.edge_cnt >= 3'h2
        |=> ext_clk_mode ##1 r.osc_cnt == 9'h000)
        else $error("external clock not detected");

    a_int_restart: assert property (win_end && r.edge_cnt < 3'h2
        |=> !ext_clk_mode ##[1:400] conv_tick)
        else $error("internal oscillator did not restart");

    a_eoc_conv: assert property ((conv_state == CCS_CONV) |-> eoc_bit ##0 !conv_done)
        else $error("eoc low during conversion");

    a_done_len: assert property (conv_done
        |-> $past(r.conv_cnt) == CONV_TICKS - 14'h0001 && !eoc_bit)
        else $error("conversion length wrong");

    a_int_tick_gap: assert property (conv_tick && !r.ext && !r.notch50
        && !$past(r.ext, 330) |-> ##1 (!conv_tick)[*8])
        else $error("60Hz tick spacing wrong");

    a_sck_div: assert property ($changed(sck_int) && $past(sck_run)
        |-> $past(r.tick) && $past(r.sck_div) == 2'h3)
        else $error("serial clock not divided by 8");

    // oscillator wrap points; together with the no-early check they pin the 60Hz tick period
    sequence s_osc60_wrap;
        !r.ext && !r.notch50 && (r.osc_cnt == OSC60_LIM);
    endsequence

    sequence s_osc50_wrap;
        !r.ext && r.notch50 && (r.osc_cnt == OSC50_LIM);
    endsequence

    a_osc60_wrap: assert property (s_osc60_wrap |=> conv_tick && r.osc_cnt == 9'h000)
        else $error("60Hz oscillator did not wrap");

    a_osc50_wrap: assert property (s_osc50_wrap |=> conv_tick && r.osc_cnt == 9'h000)
        else $error("50Hz oscillator did not wrap");

    a_osc_no_early: assert property (!r.ext && (r.osc_cnt < OSC60_LIM) |=> !conv_tick)
        else $error("internal tick came early");

    // external source: oscillator parked, one tick per synced rising edge
    a_ext_osc_off: assert property (ext_clk_mode |=> r.osc_cnt == 9'h000)
        else $error("internal oscillator ran in external mode");

    a_ext_tick: assert property (r.ext |=> conv_tick == $past(pin_rise))
        else $error("external tick does not follow pin");

    // mode may only move at a window end, so a single level change cannot flip the source
    a_mode_hold: assert property (!win_end |=> $stable(ext_clk_mode))
        else $error("clock mode changed inside a window");

    a_win_bound: assert property (r.win_cnt < DET_WIN_CYC)
        else $error("detect window overran");

    // a stray start or a level change must not move a running conversion
    a_conv_hold: assert property ((conv_state == CCS_CONV) && !r.tick
        |=> conv_state == CCS_CONV && $stable(r.conv_cnt))
        else $error("conversion moved without a tick");

    a_sleep_idle: assert property ((conv_state == CCS_SLEEP) && !start_conv
        |=> conv_state == CCS_SLEEP && $stable(notch_50hz))
        else $error("sleep disturbed without a start");

    // the coded word only changes on a new result, whatever the clock source does
    a_word_hold: assert property (!result_valid |=> $stable(out_word))
        else $error("output word changed without a result");

    a_sck_low: assert property (!sck_run |=> !sck_int)
        else $error("serial clock ran while stopped");

endmodule

// ==== test/ccs_host.sv ====
// host model that drives the rejection select pin as a level or a clock
`timescale 1ns/1ps
module ccs_host (
    input  wire logic        clk,    // bench clock
    input  wire logic        clk_on, // run the pin as an external clock
    input  wire logic        level,  // static level while not clocking
    input  wire logic [15:0] half,   // half period in clk cycles
    output logic             pin     // rejection select pin
);
    int cnt;
    initial pin = 1'b0;
    initial cnt = 0;
    // level select, or a clock far above the 2560Hz floor
    always @(negedge clk) begin
        if (!clk_on) begin
            pin <= level;
            cnt <= 0;
        end else if (cnt >= half - 1) begin
            pin <= ~pin;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the conversion clock select block
`timescale 1ns/1ps
module tb;
    import ccs_pkg::*;
    logic clk, rst, clk_on, level, start_conv, result_valid, result_over, result_under;
    logic sck_run, pin, ext_clk_mode, notch_50hz, eoc_bit, conv_done, conv_tick, sck_int;
    logic signed [28:0] result_value;
    logic [31:0]        out_word;
    ccs_state_t         conv_state;
    int                 error_cnt = 0;
    int                 n_compared = 0;
    int                 cycles = 0;
    logic [31:0]        exp_q[$];
    logic signed [28:0] vals[4] = '{29'h1FFF_FFFF, 29'h0000_0000, 29'h0FFF_FFFF, 29'h1000_0000};

    ccs_host host (.clk(clk), .clk_on(clk_on), .level(level), .half(16'h000A), .pin(pin));
    // short counts keep the run brief: 20 ticks, 200-cycle detect window
    ccs_top #(.CONV_TICKS(14'h0014), .DET_WIN_CYC(15'h00C8)) dut (
        .clk(clk), .rst(rst), .rejection_select_clock_pin(pin), .start_conv(start_conv),
        .result_valid(result_valid), .result_over(result_over), .result_under(result_under),
        .result_value(result_value), .sck_run(sck_run), .ext_clk_mode(ext_clk_mode),
        .notch_50hz(notch_50hz), .eoc_bit(eoc_bit), .conv_done(conv_done),
        .conv_tick(conv_tick), .sck_int(sck_int), .out_word(out_word), .conv_state(conv_state));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard, well above the roughly 29000 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // model codes the word from integers; over wins over under
    task automatic send_word(logic ov, logic un, logic signed [28:0] v);
        int iv;
        iv = v;
        @(negedge clk);
        result_valid = 1'b1;
        result_over = ov;
        result_under = un;
        result_value = v;
        if (ov) exp_q.push_back(32'h3000_0000);
        else if (un) exp_q.push_back(32'h0FFF_FFFF);
        else exp_q.push_back((iv >= 0 ? 32'h2000_0000 : 32'h0000_0000) | (32'(iv) & 32'h1FFF_FFFF));
        @(negedge clk);
        result_valid = 1'b0;
        check("out_word", out_word, exp_q.pop_front());
    endtask

    // one conversion; a second start mid-way must be ignored, flip moves the level
    task automatic run_conv(int spacing, logic exp_n, logic flip);
        int ticks, gap, last, t;
        ticks = 0;
        gap = 0;
        last = 0;
        @(negedge clk);
        start_conv = 1'b1;
        @(negedge clk);
        check("eoc_bit", 32'(eoc_bit), 32'h0000_0001);
        for (t = 0; t < 20000 && conv_done !== 1'b1; t++) begin
            start_conv = (t == 5);
            if (flip && t == 100) level = ~level;
            if (conv_tick === 1'b1) begin
                gap = t - last;
                last = t;
                ticks++;
            end
            @(negedge clk);
        end
        check("conv_done", 32'(conv_done), 32'h0000_0001);
        check("eoc_bit", 32'(eoc_bit), 32'h0000_0000);
        if (!flip) begin
            check("ticks", 32'(ticks), 32'h0000_0014);
            check("tick_gap", 32'(gap), 32'(spacing));
            check("notch_50hz", 32'(notch_50hz), 32'(exp_n));
        end
        @(negedge clk);
        check("state", 32'(conv_state), 32'(CCS_SLEEP));
    endtask

    initial begin
        int t0, t;
        {clk_on, level, start_conv, result_valid, result_over, result_under, sck_run} = '0;
        result_value = '0;
        rst = 1'b1;
        void'($urandom(32'ha786));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("rst_word", out_word, 32'h0000_0000);
        foreach (vals[i]) send_word(1'b0, 1'b0, vals[i]);
        send_word(1'b1, 1'b0, 29'h0000_0005);
        send_word(1'b0, 1'b1, 29'h0000_0005);
        send_word(1'b1, 1'b1, 29'h0000_0005);
        repeat (8) send_word($urandom % 2, $urandom % 2, 29'($urandom));
        run_conv(324, 1'b0, 1'b0);
        run_conv(324, 1'b0, 1'b1);
        run_conv(390, 1'b1, 1'b0);
        // external clock: 20-cycle period, notch keeps its old value
        clk_on = 1'b1;
        repeat (410) @(negedge clk);
        check("ext_on", 32'(ext_clk_mode), 32'h0000_0001);
        run_conv(20, 1'b1, 1'b0);
        sck_run = 1'b1;
        for (t = 0; t < 200 && sck_int !== 1'b1; t++) @(negedge clk);
        t0 = cycles;
        for (t = 0; t < 200 && sck_int !== 1'b0; t++) @(negedge clk);
        check("sck_half", 32'(cycles - t0), 32'h0000_0050);
        sck_run = 1'b0;
        clk_on = 1'b0;
        level = 1'b0;
        repeat (410) @(negedge clk);
        check("ext_off", 32'(ext_clk_mode), 32'h0000_0000);
        run_conv(324, 1'b0, 1'b0);
        results();
    end
endmodule
